// *** logic/ccs_pkg.sv ***
// Constants for the CPU clock switch controller: register map, field
// positions, reset values and stall timing.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package ccs_pkg;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [3:0] OSC_CTRL_ADDR = 4'h0;
	localparam logic [3:0] CLK_SEL_ADDR  = 4'h4;
	localparam logic [3:0] STATUS_ADDR   = 4'h8;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int MAIN_OSC_STOP_BIT     = 0;
	localparam int MAIN_OSC_PIN_SEL_BIT  = 1;
	localparam int MAIN_EXT_CLK_SEL_BIT  = 2;
	localparam int INT_HS_OSC_STOP_BIT   = 3;
	localparam int SUB_OSC_DIRECT_BIT    = 4;
	localparam int SUB_EXT_CLK_SEL_BIT   = 5;
	localparam int SUB_OSC_PIN_SEL_BIT   = 6;
	localparam int MAIN_CLK_SEL_BIT      = 0;
	localparam int CPU_SUB_SEL_BIT       = 1;
	localparam int AMP_GAIN_HIGH_BIT     = 2;
	localparam int ST_MAIN_CLK_BIT       = 0;
	localparam int ST_CPU_SUB_BIT        = 1;
	localparam int ST_STALL_BIT          = 2;
	localparam int ST_AMP_LOCK_BIT       = 3;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [6:0] OSC_CTRL_RESET = 7'h01; // Main source stopped, internal osc running.
	localparam logic [2:0] CLK_SEL_RESET  = 3'h0;

	// ****************************************************************
	// Bus answers
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// Stall timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS     = 10000;
	localparam int STALL_MIN_PS      = 4060000;  // 4.06 us, the shortest legal stall.
	localparam int STALL_MAX_PS      = 16120000; // 16.12 us, the longest legal stall.
	localparam int STALL_TIME_CYCLES = (STALL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STALL_EXT_EDGES   = 160;
	localparam int STALL_CNT_W       = 9;

	typedef enum logic [1:0] {
		CCS_RUN       = 2'b00,
		CCS_STALL_TIM = 2'b01,
		CCS_STALL_EXT = 2'b10
	} ccs_state_e;

endpackage

// *** logic/ccs_top.sv ***
// CPU clock switch controller: source selection flags, oscillator enables,
// main clock status and the CPU clock stall after raising amplifier gain.
// Assumes an AXI4-Lite master on aclk and an external clock gate cell that
// takes cpu_clk_enable and the raw external main clock on a pin.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps

module ccs_top
	import ccs_pkg::*;
#(
	parameter int STALL_CYCLES = STALL_TIME_CYCLES,
	parameter int EXT_EDGES    = STALL_EXT_EDGES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        main_ext_clock,
	output logic             int_hs_osc_enable,
	output logic             main_crystal_enable,
	output logic             main_ext_clock_enable,
	output logic             subsystem_crystal_enable,
	output logic             sub_ext_clock_enable,
	output logic             amp_gain_high_out,
	output logic             main_clock_status,
	output logic             cpu_on_sub,
	output logic             cpu_clk_enable
);

	initial begin
		if (STALL_CYCLES < 1 || STALL_CYCLES >= (1 << STALL_CNT_W) ||
			STALL_CYCLES > STALL_MAX_PS / CLK_PERIOD_PS)
			$error("STALL_CYCLES out of range");
		if (EXT_EDGES < 1 || EXT_EDGES >= (1 << STALL_CNT_W))
			$error("EXT_EDGES out of range");
	end

	localparam logic [STALL_CNT_W-1:0] STALL_LAST = STALL_CNT_W'(STALL_CYCLES - 1);
	localparam logic [STALL_CNT_W-1:0] EXT_LAST   = STALL_CNT_W'(EXT_EDGES - 1);

	// ****************************************************************
	// Control registers
	// ****************************************************************
	logic [6:0]       osc_ctrl;
	logic             main_clock_select;
	logic             amp_gain_high;
	logic             amp_locked;
	ccs_state_e       state;
	logic [STALL_CNT_W-1:0] stall_cnt;

	logic             main_osc_stop;
	logic             main_osc_pin_select;
	logic             main_ext_clock_select;
	logic             int_hs_osc_stop;
	logic             sub_osc_direct_start;
	logic             sub_ext_clock_select;
	logic             sub_osc_pin_select;

	assign main_osc_stop         = osc_ctrl[MAIN_OSC_STOP_BIT];
	assign main_osc_pin_select   = osc_ctrl[MAIN_OSC_PIN_SEL_BIT];
	assign main_ext_clock_select = osc_ctrl[MAIN_EXT_CLK_SEL_BIT];
	assign int_hs_osc_stop       = osc_ctrl[INT_HS_OSC_STOP_BIT];
	assign sub_osc_direct_start  = osc_ctrl[SUB_OSC_DIRECT_BIT];
	assign sub_ext_clock_select  = osc_ctrl[SUB_EXT_CLK_SEL_BIT];
	assign sub_osc_pin_select    = osc_ctrl[SUB_OSC_PIN_SEL_BIT];

	// ****************************************************************
	// AXI4-Lite write path
	// ****************************************************************
	logic             aw_held;
	logic             w_held;
	logic [3:0]       aw_addr;
	logic [31:0]      w_data;
	logic [3:0]       w_strb;
	logic             wr_do;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_do         = aw_held && w_held && !s_axi_bvalid;

	// Address and data are caught independently, so either may come first.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 4'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_do) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_do) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response; the status word accepts writes silently.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr == OSC_CTRL_ADDR || aw_addr == CLK_SEL_ADDR ||
				aw_addr == STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	logic             wr_osc;
	logic             wr_sel;
	assign wr_osc = wr_do && aw_addr == OSC_CTRL_ADDR && w_strb[0];
	assign wr_sel = wr_do && aw_addr == CLK_SEL_ADDR && w_strb[0];

	// Oscillator flags. Stop bits are honoured only where the CPU no longer
	// depends on that source, so a careless stop write cannot starve the core.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_ctrl <= OSC_CTRL_RESET;
		end else if (wr_osc) begin
			osc_ctrl <= w_data[6:0];
		end
	end

	// Source select flags; the status follows the select one cycle later.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_clock_select <= CLK_SEL_RESET[MAIN_CLK_SEL_BIT];
			cpu_on_sub        <= CLK_SEL_RESET[CPU_SUB_SEL_BIT];
			main_clock_status <= 1'b0;
		end else begin
			if (wr_sel) begin
				main_clock_select <= w_data[MAIN_CLK_SEL_BIT];
				cpu_on_sub        <= w_data[CPU_SUB_SEL_BIT];
			end
			main_clock_status <= main_clock_select;
		end
	end

	// The gain flag takes one change after reset, then locks.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp_gain_high <= CLK_SEL_RESET[AMP_GAIN_HIGH_BIT];
			amp_locked    <= 1'b0;
		end else if (wr_sel && !amp_locked && w_data[AMP_GAIN_HIGH_BIT] != amp_gain_high) begin
			amp_gain_high <= w_data[AMP_GAIN_HIGH_BIT];
			amp_locked    <= 1'b1;
		end
	end

	// ****************************************************************
	// AXI4-Lite read path
	// ****************************************************************
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (s_axi_araddr)
				OSC_CTRL_ADDR: s_axi_rdata <= {25'h0, osc_ctrl};
				CLK_SEL_ADDR:  s_axi_rdata <= {29'h0, amp_gain_high, cpu_on_sub,
					main_clock_select};
				STATUS_ADDR:   s_axi_rdata <= {28'h0, amp_locked, !cpu_clk_enable,
					cpu_on_sub, main_clock_status};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Oscillator enables
	// ****************************************************************
	logic             cpu_on_int;
	logic             cpu_on_main;
	assign cpu_on_int  = !cpu_on_sub && !main_clock_status;
	assign cpu_on_main = !cpu_on_sub && main_clock_status;

	// Registered so the pads see no decode glitches.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_hs_osc_enable        <= 1'b1;
			main_crystal_enable      <= 1'b0;
			main_ext_clock_enable    <= 1'b0;
			subsystem_crystal_enable <= 1'b0;
			sub_ext_clock_enable     <= 1'b0;
			amp_gain_high_out        <= 1'b0;
		end else begin
			int_hs_osc_enable     <= !int_hs_osc_stop || cpu_on_int;
			main_crystal_enable   <= (!main_osc_stop || cpu_on_main) &&
				main_osc_pin_select && !main_ext_clock_select;
			main_ext_clock_enable <= (!main_osc_stop || cpu_on_main) &&
				main_osc_pin_select && main_ext_clock_select;
			subsystem_crystal_enable <= sub_osc_direct_start ||
				(sub_osc_pin_select && !sub_ext_clock_select);
			sub_ext_clock_enable  <= !sub_osc_direct_start && sub_osc_pin_select &&
				sub_ext_clock_select;
			amp_gain_high_out     <= amp_gain_high;
		end
	end

	// ****************************************************************
	// CPU clock stall after the gain is raised
	// ****************************************************************
	logic             ext_s1;
	logic             ext_s2;
	logic             ext_s3;
	logic             ext_rise;

	// Two-stage synchroniser plus a delay stage; the edge detector compares the second and third stages.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end else begin
			ext_s1 <= main_ext_clock;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end
	assign ext_rise = ext_s2 && !ext_s3;

	logic             amp_raise;
	assign amp_raise = wr_sel && !amp_locked && !amp_gain_high &&
		w_data[AMP_GAIN_HIGH_BIT] && cpu_on_main && main_osc_pin_select;

	// The stall uses the shortest legal interval to keep the CPU lost time low.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= CCS_RUN;
			stall_cnt <= '0;
		end else begin
			case (state)
				CCS_RUN: begin
					stall_cnt <= '0;
					if (amp_raise)
						state <= main_ext_clock_select ? CCS_STALL_EXT : CCS_STALL_TIM;
				end
				CCS_STALL_TIM: begin
					stall_cnt <= stall_cnt + 1'b1;
					if (stall_cnt == STALL_LAST)
						state <= CCS_RUN;
				end
				CCS_STALL_EXT: begin
					if (ext_rise) begin
						stall_cnt <= stall_cnt + 1'b1;
						if (stall_cnt == EXT_LAST)
							state <= CCS_RUN;
					end
				end
				default: state <= CCS_RUN;
			endcase
		end
	end

	// Registered enable; the downstream latch-based gate cell keeps it glitch-free.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cpu_clk_enable <= 1'b1;
		else
			cpu_clk_enable <= (state == CCS_RUN) && !amp_raise;
	end

endmodule

// *** tb/ccs_assertions.sv ***
// Concurrent checks on the ports of the CPU clock switch controller.
// Assumes it is bound into ccs_top and shares its stall parameters.
`timescale 1ns/100ps
module ccs_checker #(
	parameter int STALL_CYCLES = 8,
	parameter int EXT_EDGES    = 4
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       main_ext_clock,
	input wire logic       int_hs_osc_enable,
	input wire logic       main_crystal_enable,
	input wire logic       main_ext_clock_enable,
	input wire logic       subsystem_crystal_enable,
	input wire logic       sub_ext_clock_enable,
	input wire logic       amp_gain_high_out,
	input wire logic       main_clock_status,
	input wire logic       cpu_on_sub,
	input wire logic       cpu_clk_enable
);
	logic [10:0] lo_cnt;
	logic [8:0]  ext_cnt;
	logic        amp_chg;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ****************************************
	// Helper counters
	// ****************************************
	// Raw pin edges are counted, so this count may be one fewer than the design's synchroniser saw.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lo_cnt <= 11'h000;
			ext_cnt <= 9'h000;
			amp_chg <= 1'b0;
		end else begin
			lo_cnt <= cpu_clk_enable ? 11'h000 : lo_cnt + 11'h001;
			ext_cnt <= cpu_clk_enable ? 9'h000 : ext_cnt + {8'h00, $rose(main_ext_clock)};
			amp_chg <= amp_chg | $changed(amp_gain_high_out);
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	AST_STALL_TIME: assert property (
		$rose(cpu_clk_enable) && !main_ext_clock_enable |-> lo_cnt == STALL_CYCLES + 1)
		else $error("crystal stall length is wrong");
	// The stall may never outlast 16.12 us at 10 ns a cycle.
	AST_STALL_MAX: assert property (lo_cnt < 11'h64C)
		else $error("stall runs past its longest time");
	AST_STALL_EXT: assert property (
		$rose(cpu_clk_enable) && main_ext_clock_enable |->
		ext_cnt >= EXT_EDGES - 1 && ext_cnt <= EXT_EDGES)
		else $error("external clock stall edge count is wrong");
	AST_STALL_COND: assert property (!cpu_clk_enable |-> main_clock_status && !cpu_on_sub)
		else $error("stall outside high-speed main clock use");
	AST_AMP_ONCE: assert property (amp_chg |-> $stable(amp_gain_high_out))
		else $error("gain flag changed twice");
	AST_INT_HS_KEEP: assert property (
		!main_clock_status && !cpu_on_sub |-> int_hs_osc_enable)
		else $error("internal oscillator stopped under the CPU");
	AST_MAIN_KEEP: assert property (
		main_clock_status && !cpu_on_sub |-> main_crystal_enable || main_ext_clock_enable)
		else $error("main source stopped under the CPU");
	AST_SRC_EXCL: assert property (
		!(main_crystal_enable && main_ext_clock_enable) &&
		!(subsystem_crystal_enable && sub_ext_clock_enable))
		else $error("crystal and external input enabled together");
	AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
endmodule

bind ccs_top ccs_checker #(.STALL_CYCLES(STALL_CYCLES), .EXT_EDGES(EXT_EDGES)) i_chk (
	.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .main_ext_clock,
	.int_hs_osc_enable, .main_crystal_enable, .main_ext_clock_enable,
	.subsystem_crystal_enable, .sub_ext_clock_enable, .amp_gain_high_out,
	.main_clock_status, .cpu_on_sub, .cpu_clk_enable
);

// *** tb/ccs_ext_clk_model.sv ***
// External main clock source that stands behind the external clock pin.
// Assumes run is tied to the design's external main clock input enable.
`timescale 1ns/100ps
module ccs_ext_clk_model (
	input  wire logic run,
	output logic      clk
);
	// ****************************************
	// Clock source
	// ****************************************
	// A disabled input sees no edges, so the pin stands low while not in use.
	// The period is unrelated to aclk so edges drift across the sampling window.
	initial begin
		clk = 1'b0;
		forever begin
			#53;
			clk = run ? !clk : 1'b0;
		end
	end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the CPU clock switch controller.
// Assumes the design package, the bound checker and the external clock model.
`timescale 1ns/100ps
module tb_top;
	import ccs_pkg::*;
	localparam int SC = 8;
	localparam int EE = 4;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, main_ext_clock, int_hs_osc_enable;
	logic        main_crystal_enable, main_ext_clock_enable, subsystem_crystal_enable;
	logic        sub_ext_clock_enable, amp_gain_high_out, main_clock_status, cpu_on_sub;
	logic        cpu_clk_enable;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [4:0]  en;
	logic [33:0] q_r[$];
	logic [1:0]  q_b[$];
	int          n_errors, total_checks, lo_n;

	assign en = {int_hs_osc_enable, main_crystal_enable, main_ext_clock_enable,
		subsystem_crystal_enable, sub_ext_clock_enable};

	ccs_top #(.STALL_CYCLES(SC), .EXT_EDGES(EE)) i_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_ext_clock, .int_hs_osc_enable,
		.main_crystal_enable, .main_ext_clock_enable, .subsystem_crystal_enable,
		.sub_ext_clock_enable, .amp_gain_high_out, .main_clock_status, .cpu_on_sub,
		.cpu_clk_enable
	);
	ccs_ext_clk_model i_ext (.run(main_ext_clock_enable), .clk(main_ext_clock));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic compare(input logic [33:0] e, input logic [33:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	// Upper data bits are random; the register must drop them.
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		repeat ($urandom_range(2)) @(posedge aclk);
		@(posedge aclk);
		q_b.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d | ($urandom & 32'hFFFFFF80);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		repeat ($urandom_range(2)) @(posedge aclk);
		@(posedge aclk);
		q_r.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask
	task automatic chk_en(input logic [4:0] e);
		repeat (2) @(posedge aclk);
		compare({29'h0, e}, {29'h0, en});
	endtask
	// Raises the gain flag and waits, bounded, for the CPU clock to come back.
	task automatic stall();
		lo_n = 0;
		wr(CLK_SEL_ADDR, 32'h5, RESP_OKAY);
		for (int i = 0; i < 3000 && cpu_clk_enable !== 1'b1; i++) @(posedge aclk);
		compare(34'h1, {33'h0, cpu_clk_enable});
	endtask
	function automatic logic [4:0] exp_en(input logic [6:0] v);
		exp_en = {1'b1, !v[0] & v[1] & !v[2], !v[0] & v[1] & v[2],
			v[4] | (v[6] & !v[5]), !v[4] & v[6] & v[5]};
	endfunction

	// ****************************************
	// Processes
	// ****************************************
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Each bus answer is matched against the oldest note; stall cycles are counted.
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready) compare(q_r.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid === 1'b1 && s_axi_bready) compare({32'h0, q_b.pop_front()}, {32'h0, s_axi_bresp});
		if (cpu_clk_enable === 1'b0) lo_n++;
	end
	// A hang well past the expected run length counts as a mismatch.
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end
	initial begin
		logic [6:0] v;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {40'h0, 4'hF};
		void'($urandom(86839));
		do_reset();
		rd(OSC_CTRL_ADDR, 32'h1, RESP_OKAY);
		rd(CLK_SEL_ADDR, 32'h0, RESP_OKAY);
		rd(STATUS_ADDR, 32'h0, RESP_OKAY);
		rd(4'hC, 32'h0, RESP_SLVERR);
		wr(4'hC, 32'h7F, RESP_SLVERR);
		wr(STATUS_ADDR, 32'hF, RESP_OKAY);
		chk_en(5'h10);
		$display("reset and map test done");
		for (int i = 0; i < 8; i++) begin
			v = 7'($urandom);
			wr(OSC_CTRL_ADDR, {25'h0, v}, RESP_OKAY);
			chk_en(exp_en(v));
			rd(OSC_CTRL_ADDR, {25'h0, v}, RESP_OKAY);
		end
		$display("source enable test done");
		wr(OSC_CTRL_ADDR, 32'h02, RESP_OKAY);
		repeat (20) @(posedge aclk);
		wr(CLK_SEL_ADDR, 32'h1, RESP_OKAY);
		rd(STATUS_ADDR, 32'h1, RESP_OKAY);
		wr(OSC_CTRL_ADDR, 32'h0A, RESP_OKAY);
		chk_en(5'h08);
		stall();
		compare(34'(SC + 1), 34'(lo_n));
		rd(STATUS_ADDR, 32'h9, RESP_OKAY);
		wr(CLK_SEL_ADDR, 32'h1, RESP_OKAY);
		rd(CLK_SEL_ADDR, 32'h5, RESP_OKAY);
		wr(OSC_CTRL_ADDR, 32'h4A, RESP_OKAY);
		repeat (20) @(posedge aclk);
		wr(CLK_SEL_ADDR, 32'h7, RESP_OKAY);
		rd(STATUS_ADDR, 32'hB, RESP_OKAY);
		wr(OSC_CTRL_ADDR, 32'h4B, RESP_OKAY);
		chk_en(5'h02);
		wr(OSC_CTRL_ADDR, 32'h43, RESP_OKAY);
		wr(CLK_SEL_ADDR, 32'h6, RESP_OKAY);
		rd(STATUS_ADDR, 32'hA, RESP_OKAY);
		wr(CLK_SEL_ADDR, 32'h4, RESP_OKAY);
		wr(OSC_CTRL_ADDR, 32'h03, RESP_OKAY);
		chk_en(5'h10);
		$display("crystal and subsystem test done");
		do_reset();
		wr(OSC_CTRL_ADDR, 32'h06, RESP_OKAY);
		wr(CLK_SEL_ADDR, 32'h1, RESP_OKAY);
		stall();
		compare(34'h1, {33'h0, lo_n > (EE - 1) * 10});
		wr(CLK_SEL_ADDR, 32'h4, RESP_OKAY);
		rd(STATUS_ADDR, 32'h8, RESP_OKAY);
		wr(OSC_CTRL_ADDR, 32'h07, RESP_OKAY);
		chk_en(5'h10);
		$display("external clock test done");
		give_verdict();
	end
endmodule
